//--- hdl/rmcr_pkg.sv
package rmcr_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] LANE_PWR_OFS  = 8'h09;
    localparam logic [7:0] MODE_EQ_OFS   = 8'h0A;
    // ------------------------------------------------------------
    // lane_and_power_control fields
    // ------------------------------------------------------------
    localparam int LANE_REORDER_BIT      = 7;
    localparam int PAIR_INVERT_BIT       = 6;
    localparam int LP_RSVD_BIT           = 5;
    localparam int ACT_DETECT_BIT        = 4;
    localparam int FORCED_PD_BIT         = 3;
    localparam int SLEEP_INHIBIT_BIT     = 2;
    localparam int RATE_LSB              = 0;
    localparam logic [1:0] RATE_RST      = 2'h2;
    localparam logic [1:0] RATE_400K     = 2'h3;
    // ------------------------------------------------------------
    // mode_and_equalizer_control fields
    // ------------------------------------------------------------
    localparam int PLACEMENT_BIT         = 7;
    localparam int HP_BLOCK_BIT          = 6;
    localparam int ADAPTIVE_EQ_BIT       = 5;
    localparam int EQ_ON_BIT             = 4;
    localparam int ME_RSVD_BIT           = 3;
    localparam int COMMIT_BIT            = 2;
    localparam int MODE_LSB              = 0;
    localparam logic       PLACEMENT_RST = 1'b1;
    localparam logic       ADAPTIVE_RST  = 1'b1;
    localparam logic       EQ_ON_RST     = 1'b1;
    localparam logic [1:0] MODE_RST      = 2'h1;
    localparam logic [1:0] MODE_REDRIVER = 2'h0;
    localparam logic [1:0] MODE_AUTO     = 2'h1;
    localparam logic [1:0] MODE_RATIO    = 2'h2;
    localparam logic [1:0] MODE_RETIMER  = 2'h3;
    localparam logic [7:0] ZERO_BYTE     = 8'h00;
endpackage : rmcr_pkg

//--- hdl/rmcr_strap_field.sv
`timescale 1ns/1ps
module rmcr_strap_field #(
    parameter int         W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         clk_i,
    input  wire logic         sys_rst_i,
    input  wire logic         ce_i,
    input  wire logic         override_i,
    input  wire logic [W-1:0] strap_i,
    input  wire logic         wr_i,
    input  wire logic [W-1:0] wdata_i,
    output logic      [W-1:0] value_o
);
    logic [W-1:0] value_d;

    // track strap when override low, else hold host value
    assign value_d = !override_i ? strap_i : (wr_i ? wdata_i : value_o);

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            value_o <= RST;
        end else if (ce_i) begin
            value_o <= value_d;
        end
    end
endmodule : rmcr_strap_field

//--- hdl/rmcr_regs.sv
`timescale 1ns/1ps
// Contract
// - bit 7 of 0x09 reorders input lanes in both operations; resets 0.
// - bit 6 of 0x09 inverts input pairs, retimer operation only; resets 0.
// - reorder and invert bits follow lane-order strap; writes ignored override low.
// - bit 4 of 0x09 enables activity detect standby, redriver only.
// - activity detect bit follows its strap; writes ignored override low.
// - bit 3 of 0x09 forces lowest power state; resets 0.
// - bit 2 of 0x09 inhibits hot-plug driven automatic sleep; resets 0.
// - bits 1:0 of 0x09 select port rate; reset 100 kbps code.
// - bit 7 of 0x0A selects source 0 or sink 1; resets 1.
// - bit 6 of 0x0A blocks hot-plug pass-through when set.
// - bit 5 of 0x0A adaptive equalizer select, reset 1, writes gated.
// - bit 4 of 0x0A equalizer on, reset 1, writes gated by override.
// - bit 2 of 0x0A write-only self-clearing commit applies staged lane settings.
// - lane setting writes stay staged until commit is written, or pass straight through while lanes are idle.
// - bits 1:0 of 0x0A select operating mode; reset auto crossover.
// - reserved bits 5 of 0x09 and 3 of 0x0A read zero.
// - port always accepts access; strap overrides only with override high.
// - clock ratio flag 0 means clock tenth, 1 fortieth of bit rate.
module rmcr_regs (
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       ce_i,
    input  wire logic       override_i,
    input  wire logic       lane_order_strap_pin_i,
    input  wire logic       clock_activity_detect_strap_i,
    input  wire logic       downstream_hotplug_in_i,
    input  wire logic       clock_ratio_flag_i,
    input  wire logic       link_clock_present_i,
    input  wire logic       retimer_active_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    output logic      [7:0] rdata_o,
    output logic            rvalid_o,
    output logic            lane_reorder_o,
    output logic            pair_invert_o,
    output logic            clock_activity_detect_en_o,
    output logic            receiver_standby_o,
    output logic            forced_powerdown_o,
    output logic            auto_sleep_inhibit_o,
    output logic            powerdown_o,
    output logic [1:0]      config_port_rate_sel_o,
    output logic            sink_placement_o,
    output logic            hotplug_forward_block_o,
    output logic            upstream_hotplug_out_o,
    output logic            adaptive_equalizer_sel_o,
    output logic            equalizer_on_o,
    output logic            commit_lane_settings_o,
    output logic [1:0]      operating_mode_sel_o,
    output logic            applied_adaptive_eq_o,
    output logic            applied_eq_on_o,
    output logic            clock_ratio_40_o
);
    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic       sel_lp;
    logic       sel_me;
    logic       wr_lp;
    logic       wr_me;
    logic       strap_wr_lp;
    logic       strap_wr_me;
    logic       reorder_q;
    logic       invert_q;
    logic       act_det_q;
    logic       forced_pd_q;
    logic       inhibit_q;
    logic [1:0] rate_q;
    logic       placement_q;
    logic       hp_block_q;
    logic       adaptive_q;
    logic       eq_on_q;
    logic [1:0] mode_q;
    logic       apply_d;
    logic       apply_now;
    logic       lanes_idle;
    logic [7:0] lp_rd;
    logic [7:0] me_rd;
    logic [7:0] rdata_d;
    logic       standby_d;
    logic       pd_d;
    logic       eff_retimer;

    assign sel_lp      = (addr_i == rmcr_pkg::LANE_PWR_OFS);
    assign sel_me      = (addr_i == rmcr_pkg::MODE_EQ_OFS);
    // accesses always taken
    assign wr_lp       = wr_i && sel_lp;
    assign wr_me       = wr_i && sel_me;
    // strap-backed writes need override high
    assign strap_wr_lp = wr_lp && override_i;
    assign strap_wr_me = wr_me && override_i;

    // ------------------------------------------------------------
    // strap-backed fields
    // ------------------------------------------------------------
    rmcr_strap_field #(.W(1), .RST(1'b0)) u_reorder (
        .clk_i      (clk_i),
        .sys_rst_i  (sys_rst_i),
        .ce_i       (ce_i),
        .override_i (override_i),
        .strap_i    (lane_order_strap_pin_i),
        .wr_i       (strap_wr_lp),
        .wdata_i    (wdata_i[rmcr_pkg::LANE_REORDER_BIT]),
        .value_o    (reorder_q)
    );

    rmcr_strap_field #(.W(1), .RST(1'b0)) u_invert (
        .clk_i      (clk_i),
        .sys_rst_i  (sys_rst_i),
        .ce_i       (ce_i),
        .override_i (override_i),
        .strap_i    (lane_order_strap_pin_i),
        .wr_i       (strap_wr_lp),
        .wdata_i    (wdata_i[rmcr_pkg::PAIR_INVERT_BIT]),
        .value_o    (invert_q)
    );

    rmcr_strap_field #(.W(1), .RST(1'b0)) u_act_det (
        .clk_i      (clk_i),
        .sys_rst_i  (sys_rst_i),
        .ce_i       (ce_i),
        .override_i (override_i),
        .strap_i    (clock_activity_detect_strap_i),
        .wr_i       (strap_wr_lp),
        .wdata_i    (wdata_i[rmcr_pkg::ACT_DETECT_BIT]),
        .value_o    (act_det_q)
    );

    // ------------------------------------------------------------
    // plain host fields
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            forced_pd_q <= 1'b0;
            inhibit_q   <= 1'b0;
            rate_q      <= rmcr_pkg::RATE_RST;
            placement_q <= rmcr_pkg::PLACEMENT_RST;
            hp_block_q  <= 1'b0;
            mode_q      <= rmcr_pkg::MODE_RST;
        end else if (ce_i) begin
            if (wr_lp) begin
                forced_pd_q <= wdata_i[rmcr_pkg::FORCED_PD_BIT];
                inhibit_q   <= wdata_i[rmcr_pkg::SLEEP_INHIBIT_BIT];
                rate_q      <= wdata_i[rmcr_pkg::RATE_LSB +: 2];
            end
            if (wr_me) begin
                placement_q <= wdata_i[rmcr_pkg::PLACEMENT_BIT];
                hp_block_q  <= wdata_i[rmcr_pkg::HP_BLOCK_BIT];
                mode_q      <= wdata_i[rmcr_pkg::MODE_LSB +: 2];
            end
        end
    end

    // equalizer fields: reset values, writes gated by override
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            adaptive_q <= rmcr_pkg::ADAPTIVE_RST;
            eq_on_q    <= rmcr_pkg::EQ_ON_RST;
        end else if (ce_i && strap_wr_me) begin
            adaptive_q <= wdata_i[rmcr_pkg::ADAPTIVE_EQ_BIT];
            eq_on_q    <= wdata_i[rmcr_pkg::EQ_ON_BIT];
        end
    end

    // ------------------------------------------------------------
    // commit and staged lane settings
    // ------------------------------------------------------------
    assign apply_d    = wr_me && wdata_i[rmcr_pkg::COMMIT_BIT];
    // lanes idle: settings may pass straight through
    assign lanes_idle = !downstream_hotplug_in_i || forced_pd_q
                        || (!link_clock_present_i && act_det_q);
    assign apply_now  = commit_lane_settings_o || lanes_idle;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            commit_lane_settings_o <= 1'b0;
            applied_adaptive_eq_o  <= rmcr_pkg::ADAPTIVE_RST;
            applied_eq_on_o        <= rmcr_pkg::EQ_ON_RST;
        end else if (ce_i) begin
            commit_lane_settings_o <= apply_d;
            if (apply_now) begin
                applied_adaptive_eq_o <= adaptive_q;
                applied_eq_on_o       <= eq_on_q;
            end
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    assign lp_rd   = {reorder_q, invert_q, 1'b0, act_det_q,
                      forced_pd_q, inhibit_q, rate_q};
    assign me_rd   = {placement_q, hp_block_q, adaptive_q, eq_on_q,
                      1'b0, 1'b0, mode_q};
    assign rdata_d = sel_lp ? lp_rd : (sel_me ? me_rd : rmcr_pkg::ZERO_BYTE);

    // ------------------------------------------------------------
    // lane and power logic, and registered outputs including read data, except commit strobe and applied equalizer outputs
    // ------------------------------------------------------------
    assign eff_retimer = (mode_q == rmcr_pkg::MODE_RETIMER)
                         || ((mode_q == rmcr_pkg::MODE_RATIO) && clock_ratio_flag_i)
                         || ((mode_q == rmcr_pkg::MODE_AUTO) && retimer_active_i);
    assign standby_d   = act_det_q && !eff_retimer && !link_clock_present_i;
    assign pd_d        = forced_pd_q || (!inhibit_q && !downstream_hotplug_in_i);

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rdata_o                    <= rmcr_pkg::ZERO_BYTE;
            rvalid_o                   <= 1'b0;
            lane_reorder_o             <= 1'b0;
            pair_invert_o              <= 1'b0;
            clock_activity_detect_en_o <= 1'b0;
            receiver_standby_o         <= 1'b0;
            forced_powerdown_o         <= 1'b0;
            auto_sleep_inhibit_o       <= 1'b0;
            powerdown_o                <= 1'b0;
            config_port_rate_sel_o     <= rmcr_pkg::RATE_RST;
            sink_placement_o           <= rmcr_pkg::PLACEMENT_RST;
            hotplug_forward_block_o    <= 1'b0;
            upstream_hotplug_out_o     <= 1'b0;
            adaptive_equalizer_sel_o   <= rmcr_pkg::ADAPTIVE_RST;
            equalizer_on_o             <= rmcr_pkg::EQ_ON_RST;
            operating_mode_sel_o       <= rmcr_pkg::MODE_RST;
            clock_ratio_40_o           <= 1'b0;
        end else if (ce_i) begin
            rdata_o                    <= rd_i ? rdata_d : rdata_o;
            rvalid_o                   <= rd_i;
            lane_reorder_o             <= reorder_q;
            pair_invert_o              <= invert_q && eff_retimer;
            clock_activity_detect_en_o <= act_det_q;
            receiver_standby_o         <= standby_d;
            forced_powerdown_o         <= forced_pd_q;
            auto_sleep_inhibit_o       <= inhibit_q;
            powerdown_o                <= pd_d;
            config_port_rate_sel_o     <= rate_q;
            sink_placement_o           <= placement_q;
            hotplug_forward_block_o    <= hp_block_q;
            upstream_hotplug_out_o     <= downstream_hotplug_in_i && !hp_block_q;
            adaptive_equalizer_sel_o   <= adaptive_q;
            equalizer_on_o             <= eq_on_q;
            operating_mode_sel_o       <= mode_q;
            clock_ratio_40_o           <= clock_ratio_flag_i;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence commit_wr_s;
        ce_i && wr_me && wdata_i[rmcr_pkg::COMMIT_BIT];
    endsequence
    sequence read_taken_s;
        ce_i && rd_i;
    endsequence
    sequence locked_s;
        ce_i && !override_i;
    endsequence
    sequence apply_step_s;
        ce_i && commit_lane_settings_o;
    endsequence

    commit_pulse_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        commit_wr_s |=> commit_lane_settings_o)
        else $error("commit strobe missing");
    commit_single_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        ce_i && !wr_i |=> !commit_lane_settings_o)
        else $error("commit strobe without write");
    rsvd_zero_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        read_taken_s |=> !(rdata_o[rmcr_pkg::ME_RSVD_BIT] && $past(sel_me))
        && !(rdata_o[rmcr_pkg::COMMIT_BIT] && $past(sel_me))
        && !(rdata_o[rmcr_pkg::LP_RSVD_BIT] && $past(sel_lp)))
        else $error("reserved or commit bit reads nonzero");
    strap_track_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        ce_i && !override_i |=> reorder_q == $past(lane_order_strap_pin_i))
        else $error("reorder not tracking strap");
    actdet_lock_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        ce_i && !override_i |=> act_det_q == $past(clock_activity_detect_strap_i))
        else $error("activity detect not tracking strap");
    eq_lock_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        ce_i && !override_i |=> $stable(adaptive_q) && $stable(eq_on_q))
        else $error("equalizer changed while locked");
    staged_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        ce_i && !apply_now |=> $stable(applied_eq_on_o) && $stable(applied_adaptive_eq_o))
        else $error("staged setting leaked without commit");
    hp_pass_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        ce_i && hp_block_q |=> !upstream_hotplug_out_o)
        else $error("hot-plug passed while blocked");
    forced_pd_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        ce_i && forced_pd_q |=> powerdown_o)
        else $error("forced power down ignored");
    invert_mode_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        ce_i && mode_q == rmcr_pkg::MODE_REDRIVER |=> !pair_invert_o)
        else $error("inversion in redriver mode");
    rvalid_pulse_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        read_taken_s |=> rvalid_o)
        else $error("read not answered");
    rvalid_idle_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        ce_i && !rd_i |=> !rvalid_o)
        else $error("answer without read");
    unmapped_zero_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        read_taken_s ##0 !(sel_lp || sel_me) |=> rdata_o == rmcr_pkg::ZERO_BYTE)
        else $error("unmapped read nonzero");
    invert_lock_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        locked_s |=> invert_q == $past(lane_order_strap_pin_i))
        else $error("inversion not tracking strap");
    strap_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        ce_i && override_i && !strap_wr_lp |=> $stable(reorder_q) && $stable(invert_q)
        && $stable(act_det_q))
        else $error("strap field moved without write");
    freeze_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !ce_i |=> $stable(mode_q) && $stable(rate_q) && $stable(commit_lane_settings_o)
        && $stable(rdata_o) && $stable(powerdown_o))
        else $error("state moved while clock enable low");
    standby_retimer_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        ce_i && eff_retimer |=> !receiver_standby_o)
        else $error("standby in retimer operation");
    sleep_inhibit_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        ce_i && !forced_pd_q && inhibit_q |=> !powerdown_o)
        else $error("automatic sleep while inhibited");
    auto_sleep_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        ce_i && !inhibit_q && !downstream_hotplug_in_i |=> powerdown_o)
        else $error("no automatic sleep on unplug");
    hp_forward_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        ce_i && !hp_block_q |=> upstream_hotplug_out_o == $past(downstream_hotplug_in_i))
        else $error("hot-plug not forwarded");
    reorder_out_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        ce_i |=> lane_reorder_o == $past(reorder_q))
        else $error("reorder output lost");
    commit_apply_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        apply_step_s |=> applied_eq_on_o == $past(eq_on_q)
        && applied_adaptive_eq_o == $past(adaptive_q))
        else $error("commit did not apply staged settings");
    ratio_out_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        ce_i |=> clock_ratio_40_o == $past(clock_ratio_flag_i))
        else $error("clock ratio output lost");
    mode_out_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        ce_i |=> operating_mode_sel_o == $past(mode_q))
        else $error("mode output lost");
    eq_write_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        ce_i && strap_wr_me |=> eq_on_q == $past(wdata_i[rmcr_pkg::EQ_ON_BIT]))
        else $error("equalizer write lost");
endmodule : rmcr_regs

//--- testbench/rmcr_host_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// configuration host model
// ------------------------------------------------------------
module rmcr_host_model (
    input  wire logic       clk_i,
    input  wire logic       rvalid_i,
    input  wire logic [7:0] rdata_i,
    output logic            wr_o,
    output logic            rd_o,
    output logic [7:0]      addr_o,
    output logic [7:0]      wdata_o
);
    initial begin
        wr_o    = 1'b0;
        rd_o    = 1'b0;
        addr_o  = 8'hFF;
        wdata_o = 8'h00;
    end
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        wr_o    = 1'b1;
        addr_o  = a;
        wdata_o = d;
        @(posedge clk_i);
        #1;
        wr_o    = 1'b0;
        addr_o  = ~a;
        wdata_o = ~d;
    endtask : write_reg
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
        @(posedge clk_i);
        #1;
        rd_o   = 1'b1;
        addr_o = a;
        @(posedge clk_i);
        #1;
        rd_o   = 1'b0;
        addr_o = ~a;
        for (int n = 0; n < 4 && rvalid_i !== 1'b1; n++) begin
            @(posedge clk_i);
            #1;
        end
        ok = (rvalid_i === 1'b1);
        d  = rdata_i;
    endtask : read_reg
    // sleep inhibit goes in before the fast rate
    task automatic set_fast_rate(input logic [7:0] d);
        write_reg(rmcr_pkg::LANE_PWR_OFS, {d[7:3], 3'h6});
        write_reg(rmcr_pkg::LANE_PWR_OFS, d);
    endtask : set_fast_rate
    // mode change followed by a power down toggle
    task automatic write_mode_eq(input logic [7:0] me, input logic [7:0] lp);
        write_reg(rmcr_pkg::MODE_EQ_OFS, me);
        write_reg(rmcr_pkg::LANE_PWR_OFS, lp ^ 8'h08);
        write_reg(rmcr_pkg::LANE_PWR_OFS, lp);
    endtask : write_mode_eq
endmodule : rmcr_host_model

//--- testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic       clk_i, sys_rst_i, ce_i, override_i, lane_order_strap_pin_i;
    logic       clock_activity_detect_strap_i, downstream_hotplug_in_i, clock_ratio_flag_i;
    logic       link_clock_present_i, retimer_active_i, wr_i, rd_i, rvalid_o, ok;
    logic [7:0] addr_i, wdata_i, rdata_o, rd_val, lp, me, d09, d0a;
    logic       lane_reorder_o, pair_invert_o, clock_activity_detect_en_o, receiver_standby_o;
    logic       forced_powerdown_o, auto_sleep_inhibit_o, powerdown_o, sink_placement_o;
    logic       hotplug_forward_block_o, upstream_hotplug_out_o, adaptive_equalizer_sel_o;
    logic       equalizer_on_o, commit_lane_settings_o, applied_adaptive_eq_o;
    logic       applied_eq_on_o, clock_ratio_40_o;
    logic [1:0] config_port_rate_sel_o, operating_mode_sel_o, ap;
    logic [7:0] unm [4] = '{8'h00, 8'h08, 8'h0B, 8'hFF};
    int         mismatches = 0;
    int         samples_checked = 0;

    rmcr_regs rmcr_regs_i (.clk_i, .sys_rst_i, .ce_i, .override_i, .lane_order_strap_pin_i,
        .clock_activity_detect_strap_i, .downstream_hotplug_in_i, .clock_ratio_flag_i,
        .link_clock_present_i, .retimer_active_i, .wr_i, .rd_i, .addr_i, .wdata_i, .rdata_o,
        .rvalid_o, .lane_reorder_o, .pair_invert_o, .clock_activity_detect_en_o,
        .receiver_standby_o, .forced_powerdown_o, .auto_sleep_inhibit_o, .powerdown_o,
        .config_port_rate_sel_o, .sink_placement_o, .hotplug_forward_block_o,
        .upstream_hotplug_out_o, .adaptive_equalizer_sel_o, .equalizer_on_o,
        .commit_lane_settings_o, .operating_mode_sel_o, .applied_adaptive_eq_o,
        .applied_eq_on_o, .clock_ratio_40_o);
    rmcr_host_model rmcr_host_model_i (.clk_i, .rvalid_i(rvalid_o), .rdata_i(rdata_o),
        .wr_o(wr_i), .rd_o(rd_i), .addr_o(addr_i), .wdata_o(wdata_i));

    // ------------------------------------------------------------
    // checking helpers
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic tally_and_finish();
        if (mismatches == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : tally_and_finish
    task automatic read_check(input logic [7:0] a, input logic [7:0] exp);
        rmcr_host_model_i.read_reg(a, rd_val, ok);
        check("rvalid", ok, 1'b1);
        if (ok !== 1'b1) tally_and_finish();
        check("rdata", rd_val, exp);
    endtask : read_check
    function automatic logic exp_retimer(input logic [1:0] m);
        return (m == rmcr_pkg::MODE_RETIMER) || (m == rmcr_pkg::MODE_AUTO && retimer_active_i)
            || (m == rmcr_pkg::MODE_RATIO && clock_ratio_flag_i);
    endfunction : exp_retimer
    task automatic check_outputs();
        logic rt;
        rt = exp_retimer(me[1:0]);
        check("reorder", lane_reorder_o, lp[7]);
        check("invert", pair_invert_o, lp[6] & rt);
        check("actdet", clock_activity_detect_en_o, lp[4]);
        check("standby", receiver_standby_o, lp[4] & !rt & !link_clock_present_i);
        check("forced_pd", forced_powerdown_o, lp[3]);
        check("inhibit", auto_sleep_inhibit_o, lp[2]);
        check("pd", powerdown_o, lp[3] | (!lp[2] & !downstream_hotplug_in_i));
        check("rate", config_port_rate_sel_o, lp[1:0]);
        check("sink", sink_placement_o, me[7]);
        check("block", hotplug_forward_block_o, me[6]);
        check("upstream", upstream_hotplug_out_o, downstream_hotplug_in_i & !me[6]);
        check("adaptive", adaptive_equalizer_sel_o, me[5]);
        check("eq_on", equalizer_on_o, me[4]);
        check("mode", operating_mode_sel_o, me[1:0]);
        check("ratio", clock_ratio_40_o, clock_ratio_flag_i);
        check("applied", {applied_adaptive_eq_o, applied_eq_on_o}, ap);
    endtask : check_outputs
    task automatic do_reset();
        override_i = 1'b1;
        sys_rst_i  = 1'b1;
        repeat (20) @(posedge clk_i);
        #1;
        sys_rst_i = 1'b0;
        lp = 8'h02;
        me = 8'hB1;
        ap = 2'h3;
        read_check(rmcr_pkg::LANE_PWR_OFS, lp);
        read_check(rmcr_pkg::MODE_EQ_OFS, me);
        check_outputs();
    endtask : do_reset

    // ------------------------------------------------------------
    // clock and main sequence
    // ------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        {sys_rst_i, ce_i} = 2'h3;
        {lane_order_strap_pin_i, clock_activity_detect_strap_i, downstream_hotplug_in_i} = 3'h0;
        {clock_ratio_flag_i, link_clock_present_i, retimer_active_i, override_i} = 4'h1;
        void'($urandom(32'hE2AC5C23));
        do_reset();
        for (int i = 0; i < 60; i++) begin
            @(posedge clk_i);
            #1;
            {override_i, lane_order_strap_pin_i, clock_activity_detect_strap_i,
             downstream_hotplug_in_i, clock_ratio_flag_i, link_clock_present_i,
             retimer_active_i} = 7'($urandom);
            d09 = 8'($urandom);
            d0a = 8'($urandom) & 8'hFB;
            if (i < 4) d09[1:0] = 2'(i);
            if (i < 4) d0a[1:0] = 2'(i);
            if (d09[1:0] == rmcr_pkg::RATE_400K) d09[2] = 1'b1;
            if (d09[1:0] == rmcr_pkg::RATE_400K) rmcr_host_model_i.set_fast_rate(d09);
            else rmcr_host_model_i.write_reg(rmcr_pkg::LANE_PWR_OFS, d09);
            rmcr_host_model_i.write_mode_eq(d0a, d09);
            lp = d09 & 8'hDF;
            if (!override_i) lp[7:6] = {2{lane_order_strap_pin_i}};
            if (!override_i) lp[4] = clock_activity_detect_strap_i;
            if (override_i) me[5:4] = d0a[5:4];
            me = {d0a[7:6], me[5:4], 2'h0, d0a[1:0]};
            ap = me[5:4];
            read_check(rmcr_pkg::LANE_PWR_OFS, lp);
            read_check(rmcr_pkg::MODE_EQ_OFS, me);
            check_outputs();
        end
        // staged equalizer values wait for the commit
        {override_i, downstream_hotplug_in_i, link_clock_present_i} = 3'h7;
        rmcr_host_model_i.write_reg(rmcr_pkg::LANE_PWR_OFS, 8'h00);
        lp = 8'h00;
        d0a = me ^ 8'h30;
        rmcr_host_model_i.write_reg(rmcr_pkg::MODE_EQ_OFS, d0a);
        check("commit", commit_lane_settings_o, 1'b0);
        read_check(rmcr_pkg::MODE_EQ_OFS, d0a);
        check("staged", {applied_adaptive_eq_o, applied_eq_on_o}, ap);
        rmcr_host_model_i.write_reg(rmcr_pkg::MODE_EQ_OFS, d0a | 8'h04);
        check("commit", commit_lane_settings_o, 1'b1);
        @(posedge clk_i);
        #1;
        check("commit", commit_lane_settings_o, 1'b0);
        me = d0a;
        ap = me[5:4];
        read_check(rmcr_pkg::MODE_EQ_OFS, me);
        check_outputs();
        // unmapped places read zero and keep the map intact
        foreach (unm[k]) begin
            rmcr_host_model_i.write_reg(unm[k], 8'($urandom));
            read_check(unm[k], 8'h00);
        end
        // frozen clock enable drops a write and its commit
        ce_i = 1'b0;
        rmcr_host_model_i.write_reg(rmcr_pkg::MODE_EQ_OFS, me ^ 8'hC4);
        check("frozen_commit", commit_lane_settings_o, 1'b0);
        ce_i = 1'b1;
        read_check(rmcr_pkg::LANE_PWR_OFS, lp);
        read_check(rmcr_pkg::MODE_EQ_OFS, me);
        do_reset();
        tally_and_finish();
    end
endmodule : tb_top
